// [hw/flsq_pkg.sv]
// Shared constants and types for the flash erase and program sequencer
package flsq_pkg;
  // Register block bases, one per interface
  localparam logic [23:0] PF_BASE = 24'hfff940;
  localparam logic [23:0] DF_BASE = 24'hfff740;
  // Offsets inside a register block
  localparam logic [5:0] OFF_IBAR = 6'h00;
  localparam logic [5:0] OFF_IBDR = 6'h02;
  localparam logic [5:0] OFF_WER0 = 6'h04;
  localparam logic [5:0] OFF_WER1 = 6'h06;
  localparam logic [5:0] OFF_CTRL = 6'h0c;
  localparam logic [5:0] OFF_STAT = 6'h0e;
  localparam logic [5:0] OFF_AR0 = 6'h24;
  localparam logic [5:0] OFF_AR1 = 6'h26;
  // Control and status bit positions
  localparam int CTRL_PE = 0;
  localparam int CTRL_PER = 1;
  localparam int CTRL_MER = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_ERASE_FAULT_FLAG = 2;
  localparam int STAT_PROGRAM_FAULT_FLAG = 3;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [7:0] IBAR_RESET = 8'h00;
  // Main block decode: blocks 0 and 1 by a[23:17], block 2 by a[23:13]
  localparam logic [6:0] MB0_TAG = 7'h00;
  localparam logic [6:0] MB1_TAG = 7'h01;
  localparam logic [10:0] MB2_TAG = 11'h070;
  // Page sizes in bytes and the masks that align to them
  localparam int PF_PAGE_BYTES = 1024;
  localparam int DF_PAGE_BYTES = 512;
  localparam logic [23:0] PF_PAGE_MASK = ~24'(PF_PAGE_BYTES - 1);
  localparam logic [23:0] DF_PAGE_MASK = ~24'(DF_PAGE_BYTES - 1);
  localparam logic [15:0] ALL_SECTIONS = 16'hffff;
  localparam int INFO_SEC_BIT = 15;
  // Information block words
  localparam logic [7:0] FUNC_WORD_ADDR = 8'h7e;
  localparam logic [7:0] PROT_WORD_ADDR = 8'hfe;
  localparam int USB_EN_BIT = 0;
  localparam int WRPROT_LO = 13;
  localparam int BOOT_LO = 1;
  localparam logic [2:0] BOOT_NONE = 3'h7;
  typedef enum logic [1:0] {OP_PROG, OP_PAGE, OP_BLOCK, OP_INFO} flsq_op_type;
  typedef enum {ARD_FUNC, ARD_PROT, ARD_DONE} flsq_ard_type;
endpackage

// [hw/flsq_engine.sv]
// Two-slot operation pipeline driving one flash array
`timescale 1ns/1ns
module flsq_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic reqValid,
  input wire flsq_pkg::flsq_op_type reqKind,
  input wire logic [23:0] reqAddr,
  input wire logic reqInfo,
  input wire logic [15:0] reqData,
  output logic busy,
  output logic full,
  output logic macroStart,
  output flsq_pkg::flsq_op_type macroKind,
  output logic [23:0] macroAddr,
  output logic macroInfo,
  output logic [15:0] macroData,
  input wire logic macroDone,
  input wire logic macroFail,
  output logic eraseFault,
  output logic progFault
);
  import flsq_pkg::*;
  logic curValid;
  logic pendValid;
  flsq_op_type pendKind;
  logic [23:0] pendAddr;
  logic pendInfo;
  logic [15:0] pendData;

  // Busy covers the running and the queued operation
  assign busy = curValid | pendValid;
  assign full = pendValid;

  // Running slot; a queued word is promoted the cycle its predecessor ends
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      curValid <= 1'b0;
      macroStart <= 1'b0;
      macroKind <= OP_PROG;
      macroAddr <= '0;
      macroInfo <= 1'b0;
      macroData <= REG_RESET;
    end else begin
      macroStart <= 1'b0;
      if (curValid && macroDone && pendValid) begin
        macroStart <= 1'b1;
        macroKind <= pendKind;
        macroAddr <= pendAddr;
        macroInfo <= pendInfo;
        macroData <= pendData;
      end else if (reqValid && (!curValid || macroDone)) begin
        curValid <= 1'b1;
        macroStart <= 1'b1;
        macroKind <= reqKind;
        macroAddr <= reqAddr;
        macroInfo <= reqInfo;
        macroData <= reqData;
      end else if (macroDone) begin
        curValid <= 1'b0;
      end
    end
  end

  // Waiting slot, filled only behind a running operation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pendValid <= 1'b0;
      pendKind <= OP_PROG;
      pendAddr <= '0;
      pendInfo <= 1'b0;
      pendData <= REG_RESET;
    end else if (curValid && macroDone) begin
      pendValid <= 1'b0;
    end else if (reqValid && curValid && !pendValid) begin
      pendValid <= 1'b1;
      pendKind <= reqKind;
      pendAddr <= reqAddr;
      pendInfo <= reqInfo;
      pendData <= reqData;
    end
  end

  // Failure reported by the array lands in the matching error flag
  assign eraseFault = curValid && macroDone && macroFail && (macroKind != OP_PROG);
  assign progFault = curValid && macroDone && macroFail && (macroKind == OP_PROG);

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_busy_holds: assert property (curValid && !macroDone |=> busy)
    else $error("busy dropped while an operation runs");
  sequence s_queued_done;
    pendValid ##0 macroDone;
  endsequence
  a_full_clears: assert property (s_queued_done |=> !full && busy && macroStart)
    else $error("full or promotion wrong after queued word");
endmodule

// [hw/flsq_sequencer.sv]
// Flash erase and program sequencer: registers, checks and auto-read
// Functional notes
// - Page erase only when that page's section write enable is set.
// - Page erase inside a defined boot area is refused.
// - Pages are 1024 bytes in program flash, 512 bytes in data flash.
// - Erase result lands in the erase error flag; busy holds until done.
// - Whole block erase needs every section enable of that block.
// - A block holding a defined boot area is never block erased.
// - With block erase set, any main block write erases that block.
// - Info block erase also clears its main block; no info page erase.
// - Boot area in the associated main block forbids info or block erase.
// - Info erase starts on info data write with block erase set.
// - Programming needs global protection off and the section enable set.
// - Programming inside the boot area is blocked.
// - Only aligned 16-bit word programming is accepted.
// - Each program word write starts a pipelined operation; busy meanwhile.
// - A word accepted behind a running one raises full until the running one ends.
// - Info programming uses the info address then a data register write.
// - Programming the first program-flash info block is refused.
// - Reset copies the function word at 07Eh into auto-read zero.
// - Function word bit 0 clear forces the USB transceiver to low power.
// - Full clear means the pipeline takes another word.
// - Programming only clears bits; erase must come first.
// - Reset copies the protection word into auto-read one.
`timescale 1ns/1ns
module flsq_sequencer (
  input wire logic clk,
  input wire logic reset,
  input wire logic [23:0] cpuAddr,
  input wire logic cpuWr,
  input wire logic cpuRd,
  input wire logic cpuWord,
  input wire logic [15:0] cpuWdata,
  output logic [15:0] cpuRdata,
  output logic pfStart,
  output flsq_pkg::flsq_op_type pfKind,
  output logic [23:0] pfAddr,
  output logic pfInfo,
  output logic [15:0] pfData,
  input wire logic pfDone,
  input wire logic pfFail,
  output logic dfStart,
  output flsq_pkg::flsq_op_type dfKind,
  output logic [23:0] dfAddr,
  output logic dfInfo,
  output logic [15:0] dfData,
  input wire logic dfDone,
  input wire logic dfFail,
  output logic infoRdReq,
  output logic [7:0] infoRdAddr,
  input wire logic [15:0] infoRdData,
  input wire logic infoRdValid,
  input wire logic usbCtrlActive,
  input wire logic cfgUsbEnable,
  output logic usbXcvrLowPower
);
  import flsq_pkg::*;
  // Per-interface register state, index 0 program flash, 1 data flash
  logic [7:0] ibar [2];
  logic [15:0] ibdr [2], wer0 [2];
  logic [15:0] wer1, autoReadZero, autoReadOne;
  logic [2:0] ctrl [2];
  logic [1:0] erase_fault_flag, program_fault_flag;
  flsq_ard_type ardState;
  logic arDone;
  // Decode and decision terms
  logic [1:0] regHit, mainBlk;
  logic [5:0] regOff;
  logic isMain, wrProt, bootDef;
  logic [6:0] bootPages;
  flsq_op_type reqKind [2];
  logic [23:0] reqAddr [2];
  logic [1:0] reqValid, reqInfo, setEerr, setPerr;
  logic [1:0] busy, full, eraseFault, progFault;
  logic [15:0] next_rdata;

  // Register blocks sit at their printed addresses
  assign regHit[0] = cpuAddr[23:6] == PF_BASE[23:6];
  assign regHit[1] = cpuAddr[23:6] == DF_BASE[23:6];
  assign regOff = cpuAddr[5:0];

  // Main block decode; block 2 belongs to the data flash interface
  always_comb begin
    isMain = 1'b1;
    mainBlk = 2'd0;
    if (cpuAddr[23:17] == MB0_TAG) begin
      mainBlk = 2'd0;
    end else if (cpuAddr[23:17] == MB1_TAG) begin
      mainBlk = 2'd1;
    end else if (cpuAddr[23:13] == MB2_TAG) begin
      mainBlk = 2'd2;
    end else begin
      isMain = 1'b0;
    end
  end

  // Protection taken from the auto-read copy, so it changes only at reset
  assign wrProt = !((autoReadOne[WRPROT_LO] & autoReadOne[WRPROT_LO + 1]) |
                    (autoReadOne[WRPROT_LO] & autoReadOne[WRPROT_LO + 2]) |
                    (autoReadOne[WRPROT_LO + 1] & autoReadOne[WRPROT_LO + 2]));
  assign bootDef = autoReadOne[BOOT_LO +: 3] != BOOT_NONE;
  // Inverted field counts boot pages of program flash size
  assign bootPages = {4'h0, ~autoReadOne[BOOT_LO +: 3]};

  // Trigger checks: a legal write goes to the pipeline, an illegal one flags
  always_comb begin
    logic trig, info, secEn, allEn, inBoot, progOk;
    logic [1:0] blk;
    logic [15:0] werSel;
    logic [3:0] secIdx;
    trig = 1'b0;
    info = 1'b0;
    secEn = 1'b0;
    allEn = 1'b0;
    inBoot = 1'b0;
    blk = 2'd0;
    werSel = REG_RESET;
    secIdx = 4'h0;
    progOk = 1'b0;
    for (int c = 0; c < 2; c++) begin
      reqValid[c] = 1'b0;
      reqKind[c] = OP_PROG;
      reqAddr[c] = '0;
      reqInfo[c] = 1'b0;
      setEerr[c] = 1'b0;
      setPerr[c] = 1'b0;
      info = regHit[c] && regOff == OFF_IBDR;
      trig = cpuWr && (info || (isMain && ((mainBlk == 2'd2) == (c == 1))));
      // Info blocks map onto main block 0, 1 or 2
      blk = info ? ((c == 1) ? 2'd2 : {1'b0, ibar[c][7]}) : mainBlk;
      werSel = (blk == 2'd0) ? wer0[0] : ((blk == 2'd1) ? wer1 : wer0[1]);
      secIdx = (blk == 2'd2) ? cpuAddr[12:9] : cpuAddr[16:13];
      secEn = info ? werSel[INFO_SEC_BIT] : werSel[secIdx];
      allEn = werSel == ALL_SECTIONS;
      inBoot = !info && blk == 2'd0 && bootDef &&
               cpuAddr[16:10] < bootPages;
      progOk = arDone && !wrProt && secEn && !inBoot &&
               (info || (cpuWord && !cpuAddr[0])) &&
               !(info && c == 0 && !ibar[c][7]);
      reqInfo[c] = info;
      if (info) begin
        reqAddr[c] = {16'h0000, ibar[c]};
      end else if (ctrl[c][CTRL_PER]) begin
        reqAddr[c] = cpuAddr & ((c == 0) ? PF_PAGE_MASK : DF_PAGE_MASK);
      end else begin
        reqAddr[c] = cpuAddr;
      end
      if (trig && ctrl[c][CTRL_PE]) begin
        reqKind[c] = OP_PROG;
        if (!progOk) begin
          setPerr[c] = 1'b1;
        end else if (!full[c]) begin
          reqValid[c] = 1'b1;
        end
      end else if (trig && ctrl[c][CTRL_MER]) begin
        reqKind[c] = info ? OP_INFO : OP_BLOCK;
        if (!arDone || wrProt || !allEn || (blk == 2'd0 && bootDef)) begin
          setEerr[c] = 1'b1;
        end else if (!busy[c]) begin
          reqValid[c] = 1'b1;
        end
      end else if (trig && ctrl[c][CTRL_PER]) begin
        reqKind[c] = OP_PAGE;
        if (info || !arDone || wrProt || !secEn || inBoot) begin
          setEerr[c] = 1'b1;
        end else if (!busy[c]) begin
          reqValid[c] = 1'b1;
        end
      end
    end
  end

  // Address and data registers; address bit 0 always reads back clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ibar[0] <= IBAR_RESET;
      ibar[1] <= IBAR_RESET;
      ibdr[0] <= REG_RESET;
      ibdr[1] <= REG_RESET;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cpuWr && regHit[c] && regOff == OFF_IBAR) begin
          ibar[c] <= {cpuWdata[7:1], 1'b0};
        end
        if (cpuWr && regHit[c] && regOff == OFF_IBDR) begin
          ibdr[c] <= cpuWdata;
        end
      end
    end
  end

  // Section enables clear at reset, so nothing is writable until set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wer0[0] <= REG_RESET;
      wer0[1] <= REG_RESET;
      wer1 <= REG_RESET;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cpuWr && regHit[c] && regOff == OFF_WER0) begin
          wer0[c] <= cpuWdata;
        end
      end
      if (cpuWr && regHit[0] && regOff == OFF_WER1) begin
        wer1 <= cpuWdata;
      end
    end
  end

  // Mode bits; software owns them for the whole sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ctrl[0] <= 3'h0;
      ctrl[1] <= 3'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (cpuWr && regHit[c] && regOff == OFF_CTRL) begin
          ctrl[c] <= cpuWdata[2:0];
        end
      end
    end
  end

  // Sticky error flags, write one to clear; a new error beats the clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      erase_fault_flag <= 2'b00;
      program_fault_flag <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (setEerr[c] || eraseFault[c]) begin
          erase_fault_flag[c] <= 1'b1;
        end else if (cpuWr && regHit[c] && regOff == OFF_STAT && cpuWdata[STAT_ERASE_FAULT_FLAG]) begin
          erase_fault_flag[c] <= 1'b0;
        end
        if (setPerr[c] || progFault[c]) begin
          program_fault_flag[c] <= 1'b1;
        end else if (cpuWr && regHit[c] && regOff == OFF_STAT && cpuWdata[STAT_PROGRAM_FAULT_FLAG]) begin
          program_fault_flag[c] <= 1'b0;
        end
      end
    end
  end

  // Auto-read after reset: function word, then protection word
  assign infoRdReq = ardState != ARD_DONE;
  assign infoRdAddr = (ardState == ARD_FUNC) ? FUNC_WORD_ADDR : PROT_WORD_ADDR;
  assign arDone = ardState == ARD_DONE;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ardState <= ARD_FUNC;
      autoReadZero <= REG_RESET;
      autoReadOne <= REG_RESET;
    end else begin
      unique case (ardState)
        ARD_FUNC: begin
          if (infoRdValid) begin
            autoReadZero <= infoRdData;
            ardState <= ARD_PROT;
          end
        end
        ARD_PROT: begin
          if (infoRdValid) begin
            autoReadOne <= infoRdData;
            ardState <= ARD_DONE;
          end
        end
        ARD_DONE: begin
          ardState <= ARD_DONE;
        end
      endcase
    end
  end

  // Transceiver held in low power until the word is loaded and enables it, USB is enabled and the controller is active
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      usbXcvrLowPower <= 1'b1;
    end else begin
      usbXcvrLowPower <= !(arDone && autoReadZero[USB_EN_BIT] &&
                           cfgUsbEnable && usbCtrlActive);
    end
  end

  // Register read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = REG_RESET;
    for (int c = 0; c < 2; c++) begin
      if (regHit[c]) begin
        unique case (regOff)
          OFF_IBAR: next_rdata = {8'h00, ibar[c]};
          OFF_IBDR: next_rdata = ibdr[c];
          OFF_WER0: next_rdata = wer0[c];
          OFF_WER1: next_rdata = (c == 0) ? wer1 : REG_RESET;
          OFF_CTRL: next_rdata = {13'h0000, ctrl[c]};
          OFF_STAT: begin
            next_rdata[STAT_BUSY] = busy[c];
            next_rdata[STAT_FULL] = full[c];
            next_rdata[STAT_ERASE_FAULT_FLAG] = erase_fault_flag[c];
            next_rdata[STAT_PROGRAM_FAULT_FLAG] = program_fault_flag[c];
          end
          OFF_AR0: next_rdata = (c == 0) ? autoReadZero : REG_RESET;
          OFF_AR1: next_rdata = (c == 0) ? autoReadOne : REG_RESET;
          default: next_rdata = REG_RESET;
        endcase
      end
    end
  end

  // Read data is registered, valid the cycle after the read strobe
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuRdata <= REG_RESET;
    end else if (cpuRd) begin
      cpuRdata <= next_rdata;
    end
  end

  // Program flash array engine
  flsq_engine pfEngine (
    .clk(clk), .reset(reset), .reqValid(reqValid[0]), .reqKind(reqKind[0]),
    .reqAddr(reqAddr[0]), .reqInfo(reqInfo[0]), .reqData(cpuWdata), .busy(busy[0]),
    .full(full[0]), .macroStart(pfStart), .macroKind(pfKind), .macroAddr(pfAddr),
    .macroInfo(pfInfo), .macroData(pfData), .macroDone(pfDone), .macroFail(pfFail),
    .eraseFault(eraseFault[0]), .progFault(progFault[0])
  );

  // Data flash array engine
  flsq_engine dfEngine (
    .clk(clk), .reset(reset), .reqValid(reqValid[1]), .reqKind(reqKind[1]),
    .reqAddr(reqAddr[1]), .reqInfo(reqInfo[1]), .reqData(cpuWdata), .busy(busy[1]),
    .full(full[1]), .macroStart(dfStart), .macroKind(dfKind), .macroAddr(dfAddr),
    .macroInfo(dfInfo), .macroData(dfData), .macroDone(dfDone), .macroFail(dfFail),
    .eraseFault(eraseFault[1]), .progFault(progFault[1])
  );

  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_boot_page_write;
    cpuWr && isMain && mainBlk == 2'd0 && arDone && bootDef &&
      ctrl[0] == 3'(1 << CTRL_PER) && cpuAddr[16:10] < bootPages;
  endsequence
  a_boot_page_refused: assert property (s_boot_page_write |-> !reqValid[0] ##1 erase_fault_flag[0])
    else $error("page erase in boot area not refused");
  a_prog_protected: assert property (reqValid[0] && reqKind[0] == OP_PROG |-> !wrProt)
    else $error("program accepted under write protection");
  a_info0_refused: assert property (reqValid[0] && reqInfo[0] && reqKind[0] == OP_PROG
      |-> ibar[0][7])
    else $error("program of info block 0 accepted");
  a_block_all_en: assert property (reqValid[1] && reqKind[1] == OP_BLOCK
      |-> wer0[1] == ALL_SECTIONS)
    else $error("block erase without all section enables");
  a_byte_refused: assert property (cpuWr && isMain && !cpuWord && ctrl[0] == 3'(1 << CTRL_PE)
      && mainBlk != 2'd2 |-> !reqValid[0] ##1 program_fault_flag[0])
    else $error("byte program not refused");
  a_page_aligned: assert property (reqValid[1] && reqKind[1] == OP_PAGE
      |-> reqAddr[1][8:0] == 9'h000)
    else $error("data page erase not page aligned");
  sequence s_func_read;
    ardState == ARD_FUNC && infoRdValid;
  endsequence
  a_autoread_copy: assert property (s_func_read |=> autoReadZero == $past(infoRdData))
    else $error("function word not copied");
  a_usb_lowpower: assert property (!autoReadZero[USB_EN_BIT] |=> usbXcvrLowPower)
    else $error("transceiver not forced to low power");
endmodule

// [tb/flsq_sequencer_tb.sv]
// Self-checking bench for the flash erase and program sequencer
`timescale 1ns/1ns
module flsq_sequencer_tb;
  import flsq_pkg::*;
  localparam logic [23:0] PIBAR = PF_BASE + 24'(OFF_IBAR);
  localparam logic [23:0] PIBDR = PF_BASE + 24'(OFF_IBDR);
  localparam logic [23:0] PWER0 = PF_BASE + 24'(OFF_WER0);
  localparam logic [23:0] PWER1 = PF_BASE + 24'(OFF_WER1);
  localparam logic [23:0] PCTRL = PF_BASE + 24'(OFF_CTRL);
  localparam logic [23:0] PSTAT = PF_BASE + 24'(OFF_STAT);
  localparam logic [23:0] DWER0 = DF_BASE + 24'(OFF_WER0);
  localparam logic [23:0] DCTRL = DF_BASE + 24'(OFF_CTRL);
  localparam logic [23:0] DSTAT = DF_BASE + 24'(OFF_STAT);
  // Writes allowed, boot area of one 1024-byte page
  localparam logic [15:0] PROT_IMAGE = 16'he00c;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [23:0] cpuAddr = 24'h000000;
  logic cpuWr = 1'b0;
  logic cpuRd = 1'b0;
  logic cpuWord = 1'b1;
  logic [15:0] cpuWdata = 16'h0000;
  logic [15:0] cpuRdata, pfData, dfData;
  logic pfStart, pfInfo, dfStart, dfInfo, infoRdReq, usbXcvrLowPower;
  flsq_op_type pfKind, dfKind;
  logic [23:0] pfAddr, dfAddr;
  logic pfDone = 1'b0;
  logic pfFail = 1'b0;
  logic dfDone = 1'b0;
  logic dfFail = 1'b0;
  logic [7:0] infoRdAddr;
  logic [15:0] infoRdData = 16'h0000;
  logic infoRdValid = 1'b0;
  logic usbCtrlActive = 1'b1;
  logic cfgUsbEnable = 1'b1;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [23:0] bad [4] = '{24'h000100, 24'h002004, 24'h002005, 24'h004000};
  logic badWord [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  flsq_sequencer i_dut (.clk(clk), .reset(reset), .cpuAddr(cpuAddr), .cpuWr(cpuWr),
    .cpuRd(cpuRd), .cpuWord(cpuWord), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .pfStart(pfStart), .pfKind(pfKind), .pfAddr(pfAddr), .pfInfo(pfInfo), .pfData(pfData),
    .pfDone(pfDone), .pfFail(pfFail), .dfStart(dfStart), .dfKind(dfKind), .dfAddr(dfAddr),
    .dfInfo(dfInfo), .dfData(dfData), .dfDone(dfDone), .dfFail(dfFail),
    .infoRdReq(infoRdReq), .infoRdAddr(infoRdAddr), .infoRdData(infoRdData),
    .infoRdValid(infoRdValid), .usbCtrlActive(usbCtrlActive), .cfgUsbEnable(cfgUsbEnable),
    .usbXcvrLowPower(usbXcvrLowPower));

  // Free-running clock, 8 ns period
  always #4 clk = ~clk;

  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One register or array write; the strobe is held for exactly one edge
  task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic w = 1'b1);
    @(posedge clk);
    cpuAddr <= a;
    cpuWdata <= d;
    cpuWord <= w;
    cpuWr <= 1'b1;
    @(posedge clk);
    cpuWr <= 1'b0;
    cpuWord <= 1'b1;
    #1;
  endtask

  task automatic rd(input logic [23:0] a, input logic [15:0] exp);
    @(posedge clk);
    cpuAddr <= a;
    cpuRd <= 1'b1;
    @(posedge clk);
    cpuRd <= 1'b0;
    #1;
    chk("rdata", 24'(exp), 24'(cpuRdata));
  endtask

  // Start pulse of one array; block erase address is left to the engine
  task automatic chkOp(input logic df, input logic s, input flsq_op_type k,
                       input logic [23:0] a);
    chk("start", 24'(s), 24'(df ? dfStart : pfStart));
    if (s) begin
      chk("kind", 24'(k), 24'(df ? dfKind : pfKind));
      if (k != OP_BLOCK) begin
        chk("addr", a, df ? dfAddr : pfAddr);
      end
    end
  endtask

  task automatic done(input logic df, input logic fail);
    @(posedge clk);
    {dfDone, pfDone} <= df ? 2'b10 : 2'b01;
    {dfFail, pfFail} <= {fail, fail};
    @(posedge clk);
    {dfDone, pfDone} <= 2'b00;
    #1;
  endtask

  // A refused trigger: no start, flag set, then cleared by writing one
  task automatic refused(input logic df, input logic [15:0] flag);
    chkOp(df, 1'b0, OP_PROG, 24'h0);
    rd(df ? DSTAT : PSTAT, flag);
    wr(df ? DSTAT : PSTAT, flag);
  endtask

  // Release reset and serve both auto-read words
  task automatic ard(input logic [15:0] f);
    @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("lowPwr", 24'h1, 24'(usbXcvrLowPower));
    chk("rdAddr", 24'h7e, 24'(infoRdAddr));
    @(posedge clk);
    infoRdData <= f;
    infoRdValid <= 1'b1;
    @(posedge clk);
    infoRdValid <= 1'b0;
    #1;
    chk("rdAddr", 24'hfe, 24'(infoRdAddr));
    @(posedge clk);
    infoRdData <= PROT_IMAGE;
    infoRdValid <= 1'b1;
    @(posedge clk);
    infoRdValid <= 1'b0;
    #1;
    chk("rdReq", 24'h0, 24'(infoRdReq));
  endtask

  // Drive the transceiver inputs and look at the power output two edges later
  task automatic usb(input logic act, input logic en, input logic exp);
    @(posedge clk);
    usbCtrlActive <= act;
    cfgUsbEnable <= en;
    repeat (2) @(posedge clk);
    #1;
    chk("lowPwr", 24'(exp), 24'(usbXcvrLowPower));
  endtask

  initial begin
    repeat (6) @(posedge clk);
    ard(16'h0001);
    rd(PF_BASE + 24'(OFF_AR0), 16'h0001);
    rd(PF_BASE + 24'(OFF_AR1), PROT_IMAGE);
    chk("lowPwr", 24'h0, 24'(usbXcvrLowPower));
    usb(1'b0, 1'b1, 1'b1);
    usb(1'b1, 1'b0, 1'b1);
    usb(1'b1, 1'b1, 1'b0);
    wr(PIBAR, 16'h00ff);
    rd(PIBAR, 16'h00fe);
    rd(PF_BASE + 24'h3a, 16'h0000);
    // Two words back to back: the second waits behind the first
    wr(PWER0, 16'hffff);
    wr(PWER1, 16'hffff);
    wr(PCTRL, 16'h0001);
    wr(24'h002000, 16'h1234);
    chkOp(0, 1, OP_PROG, 24'h002000);
    chk("data", 24'h1234, 24'(pfData));
    wr(24'h002002, 16'h5678);
    chkOp(0, 0, OP_PROG, 24'h0);
    rd(PSTAT, 16'h0003);
    done(0, 0);
    chkOp(0, 1, OP_PROG, 24'h002002);
    rd(PSTAT, 16'h0001);
    done(0, 0);
    rd(PSTAT, 16'h0000);
    // Boot area, byte, misaligned and disabled-section writes are refused
    wr(PWER0, 16'hfffb);
    for (int i = 0; i < 4; i++) begin
      wr(bad[i], 16'h0000, badWord[i]);
      refused(0, 16'h0008);
    end
    wr(PIBAR, 16'h0010);
    wr(PIBDR, 16'h0000);
    refused(0, 16'h0008);
    wr(PIBAR, 16'h0082);
    wr(PIBDR, 16'hbeef);
    chkOp(0, 1, OP_PROG, 24'h000082);
    chk("info", 24'h1, 24'(pfInfo));
    done(0, 0);
    // Page erase on both arrays, a failing one and a boot page
    wr(PWER0, 16'hffff);
    wr(PCTRL, 16'h0002);
    wr(24'h002345, 16'h0000);
    chkOp(0, 1, OP_PAGE, 24'h002000);
    done(0, 1);
    refused(0, 16'h0004);
    wr(24'h000200, 16'h0000);
    refused(0, 16'h0004);
    wr(PIBDR, 16'h0000);
    refused(0, 16'h0004);
    wr(DWER0, 16'hffff);
    wr(DCTRL, 16'h0002);
    wr(24'h0e0345, 16'h0000);
    chkOp(1, 1, OP_PAGE, 24'h0e0200);
    rd(DSTAT, 16'h0001);
    done(1, 0);
    rd(DSTAT, 16'h0000);
    // Data flash word program with a failing array, then a data block erase
    wr(DCTRL, 16'h0001);
    wr(24'h0e0400, 16'h00ff);
    chkOp(1, 1, OP_PROG, 24'h0e0400);
    chk("dInfo", 24'h0, 24'(dfInfo));
    chk("dData", 24'h00ff, 24'(dfData));
    done(1, 1);
    rd(DSTAT, 16'h0008);
    wr(DSTAT, 16'h0008);
    wr(DCTRL, 16'h0004);
    wr(24'h0e1ffe, 16'h0000);
    chkOp(1, 1, OP_BLOCK, 24'h0);
    done(1, 0);
    // Whole block and information block erase
    wr(PCTRL, 16'h0004);
    wr(24'h000800, 16'h0000);
    refused(0, 16'h0004);
    wr(24'h021000, 16'h0000);
    chkOp(0, 1, OP_BLOCK, 24'h0);
    done(0, 0);
    wr(PWER1, 16'h7fff);
    wr(24'h021000, 16'h0000);
    refused(0, 16'h0004);
    wr(PWER1, 16'hffff);
    wr(PIBAR, 16'h0080);
    wr(PIBDR, 16'h0000);
    chkOp(0, 1, OP_INFO, 24'h000080);
    done(0, 0);
    wr(PIBAR, 16'h0000);
    wr(PIBDR, 16'h0000);
    refused(0, 16'h0004);
    // Second reset with the transceiver bit clear keeps low power
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    ard(16'h0000);
    rd(PF_BASE + 24'(OFF_AR0), 16'h0000);
    chk("lowPwr", 24'h1, 24'(usbXcvrLowPower));
    print_verdict();
  end
endmodule
